// ===== logic/iag_map.svh
// Address map and constants of the indirect address generator
`ifndef IAG_MAP_SVH
`define IAG_MAP_SVH
// Virtual access locations of pointer 0; pointers 1 and 2 follow at stride 8
`define IAG_PORT_BASE 12'hFE0
`define IAG_PORT_STRIDE 12'h008
`define IAG_OFS_INDEX 3'h3
`define IAG_OFS_INC_BEFORE 3'h4
`define IAG_OFS_DEC_AFTER 3'h5
`define IAG_OFS_INC_AFTER 3'h6
`define IAG_OFS_PLAIN 3'h7
// Pointer byte registers: low at base + 2*n, high at base + 2*n + 1
`define IAG_PTR_BASE 12'hFD8
`define IAG_PTR_RST 12'h000
`define IAG_ZERO_BYTE 8'h00
`define IAG_HIGH_MASK 8'h0F
`endif

// ===== logic/iag_pkg.sv
// Types of the indirect address generator
package iag_pkg;
  typedef enum logic [4:0] {
    IAG_PLAIN = 5'h01,
    IAG_DEC_AFTER = 5'h02,
    IAG_INC_AFTER = 5'h04,
    IAG_INC_BEFORE = 5'h08,
    IAG_INDEX = 5'h10
  } iag_mode_t;
  typedef enum logic [1:0] {
    IAG_IDLE = 2'h1,
    IAG_BUSY = 2'h2
  } iag_state_t;
endpackage : iag_pkg

// ===== logic/iag_ptr_if.sv
// Interface carrying pointer file write and read traffic
`timescale 1ns/100ps
interface iag_ptr_if;
  logic we;
  logic [1:0] sel;
  logic [11:0] wdata;
  logic [11:0] ptr0;
  logic [11:0] ptr1;
  logic [11:0] ptr2;
  modport ctrl (output we, output sel, output wdata, input ptr0, input ptr1, input ptr2);
  modport file (input we, input sel, input wdata, output ptr0, output ptr1, output ptr2);
endinterface : iag_ptr_if

// ===== logic/iag_ptr_file.sv
// Three 12-bit pointer registers
`timescale 1ns/100ps
`include "iag_map.svh"
module iag_ptr_file (
  input wire logic clk,
  input wire logic rst,
  iag_ptr_if.file pif
);
  logic [11:0] ptr_r [3];
  logic [11:0] ptr_nxt [3];

  // ----------------------------------------
  // Pointer storage
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ptr
      // Next value: write when selected
      always_comb begin
        ptr_nxt[g] = ptr_r[g];
        if (pif.we && pif.sel == 2'(g)) begin
          ptr_nxt[g] = pif.wdata;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          ptr_r[g] <= `IAG_PTR_RST;
        end else begin
          ptr_r[g] <= ptr_nxt[g];
        end
      end
    end
  endgenerate
  assign pif.ptr0 = ptr_r[0];
  assign pif.ptr1 = ptr_r[1];
  assign pif.ptr2 = ptr_r[2];
endmodule : iag_ptr_file

// ===== logic/iag_core.sv
// Indirect data-memory address generator, top level
//
// Behaviour
// - Access to an indirect port goes to the address held in its pointer.
// - Three independent 12-bit pointers built from high and low bytes.
// - Pointer bytes sit at FD8h-FDDh, written only by indirect writes; direct accesses are ignored.
// - Indirect target that is a port: read gives 00h, sets zero; write is nop.
// - Five ports per pointer: plain, step down after, step up after, step up before, indexed.
// - Post ports access at the current pointer, then step it by one.
// - Pre-increment steps the pointer first, then accesses the new address.
// - Pointer stepping never touches any status flag.
// - Stepping works on all 12 bits, carrying between bytes.
// - Indexed address is pointer plus signed accumulator; nothing changes.
// - Indirect write into a pointer byte stores data and skips stepping.
// - Ports serve as the file operand of any data-memory instruction.
`timescale 1ns/100ps
`include "iag_map.svh"
module iag_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [11:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] working_accumulator,
  input wire logic [7:0] mem_rdata,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_zero_force,
  output logic [11:0] address_pointer_0,
  output logic [11:0] address_pointer_1,
  output logic [11:0] address_pointer_2
);
  iag_ptr_if pif ();
  iag_ptr_file u_file (.clk(clk), .rst(rst), .pif(pif));

  // Returns pointer index plus one when address is a virtual port, else zero
  function automatic logic [1:0] port_hit(input logic [11:0] a);
    logic [11:0] d;
    port_hit = 2'h0;
    for (int i = 0; i < 3; i++) begin
      d = a - (`IAG_PORT_BASE + 12'(i) * `IAG_PORT_STRIDE);
      if (d[11:3] == 9'h000 && d[2:0] >= `IAG_OFS_INDEX) port_hit = 2'(i + 1);
    end
  endfunction : port_hit

  // Returns pointer index plus one when address is a pointer byte, else zero
  function automatic logic [1:0] ptr_hit(input logic [11:0] a);
    logic [11:0] d;
    d = a - `IAG_PTR_BASE;
    ptr_hit = (d < 12'h006) ? 2'(d[2:1] + 2'h1) : 2'h0;
  endfunction : ptr_hit

  function automatic iag_pkg::iag_mode_t mode_of(input logic [2:0] o);
    case (o)
      `IAG_OFS_DEC_AFTER: mode_of = iag_pkg::IAG_DEC_AFTER;
      `IAG_OFS_INC_AFTER: mode_of = iag_pkg::IAG_INC_AFTER;
      `IAG_OFS_INC_BEFORE: mode_of = iag_pkg::IAG_INC_BEFORE;
      `IAG_OFS_INDEX: mode_of = iag_pkg::IAG_INDEX;
      default: mode_of = iag_pkg::IAG_PLAIN;
    endcase
  endfunction : mode_of

  logic [11:0] ptrs [3];
  assign ptrs[0] = pif.ptr0;
  assign ptrs[1] = pif.ptr1;
  assign ptrs[2] = pif.ptr2;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic [1:0] hit;
  logic [1:0] idx;
  logic [11:0] cur;
  logic [11:0] tgt;
  logic [11:0] upd;
  logic do_upd;
  logic [1:0] phit;
  logic [1:0] bhit;
  iag_pkg::iag_mode_t mode;

  // Target and pointer update for a virtual port access
  always_comb begin
    hit = port_hit(acc_addr);
    idx = (hit == 2'h0) ? 2'h0 : hit - 2'h1;
    cur = ptrs[idx];
    mode = mode_of(acc_addr[2:0]);
    tgt = cur;
    upd = cur;
    do_upd = 1'b0;
    case (mode)
      iag_pkg::IAG_DEC_AFTER: begin
        upd = cur - 12'h001;
        do_upd = 1'b1;
      end
      iag_pkg::IAG_INC_AFTER: begin
        upd = cur + 12'h001;
        do_upd = 1'b1;
      end
      iag_pkg::IAG_INC_BEFORE: begin
        upd = cur + 12'h001;
        tgt = upd;
        do_upd = 1'b1;
      end
      iag_pkg::IAG_INDEX: begin
        tgt = cur + {{4{working_accumulator[7]}}, working_accumulator};
      end
      default: begin
        tgt = cur;
      end
    endcase
    phit = port_hit(tgt);
    bhit = ptr_hit(tgt);
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  iag_pkg::iag_state_t state_r, state_nxt;
  logic [11:0] mem_addr_nxt;
  logic mem_rd_nxt, mem_wr_nxt, rsp_valid_nxt, zero_nxt;
  logic [7:0] mem_wdata_nxt, rsp_rdata_nxt;

  // Single-cycle issue; read data returned one cycle after the strobe
  always_comb begin
    state_nxt = state_r;
    mem_addr_nxt = mem_addr;
    mem_rd_nxt = 1'b0;
    mem_wr_nxt = 1'b0;
    mem_wdata_nxt = mem_wdata;
    rsp_valid_nxt = 1'b0;
    rsp_rdata_nxt = rsp_rdata;
    zero_nxt = 1'b0;
    pif.we = 1'b0;
    pif.sel = idx;
    pif.wdata = upd;
    case (state_r)
      iag_pkg::IAG_IDLE: begin
        if (acc_valid && hit != 2'h0) begin
          if (phit != 2'h0) begin
            // Self reference: no memory cycle at all
            rsp_valid_nxt = 1'b1;
            rsp_rdata_nxt = `IAG_ZERO_BYTE;
            zero_nxt = !acc_write;
          end else begin
            mem_addr_nxt = tgt;
            mem_rd_nxt = !acc_write;
            mem_wr_nxt = acc_write;
            mem_wdata_nxt = acc_wdata;
            rsp_valid_nxt = acc_write;
            state_nxt = acc_write ? iag_pkg::IAG_IDLE : iag_pkg::IAG_BUSY;
          end
          if (acc_write && bhit != 2'h0 && phit == 2'h0) begin
            // Write lands in a pointer byte; stepping is skipped
            pif.we = 1'b1;
            pif.sel = bhit - 2'h1;
            // High byte keeps only its low nibble, since the pointer is 12 bits wide
            pif.wdata = tgt[0] ? {acc_wdata[3:0], ptrs[bhit - 2'h1][7:0]}
                               : {ptrs[bhit - 2'h1][11:8], acc_wdata};
          end else if (do_upd && !(acc_write && phit != 2'h0)) begin
            pif.we = 1'b1; // no flag path exists here
          end
        end
      end
      iag_pkg::IAG_BUSY: begin
        rsp_valid_nxt = 1'b1;
        rsp_rdata_nxt = mem_rdata;
        state_nxt = iag_pkg::IAG_IDLE;
      end
      default: begin
        state_nxt = iag_pkg::IAG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= iag_pkg::IAG_IDLE;
      mem_addr <= 12'h000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_zero_force <= 1'b0;
      address_pointer_0 <= `IAG_PTR_RST;
      address_pointer_1 <= `IAG_PTR_RST;
      address_pointer_2 <= `IAG_PTR_RST;
    end else begin
      state_r <= state_nxt;
      mem_addr <= mem_addr_nxt;
      mem_rd <= mem_rd_nxt;
      mem_wr <= mem_wr_nxt;
      mem_wdata <= mem_wdata_nxt;
      rsp_valid <= rsp_valid_nxt;
      rsp_rdata <= rsp_rdata_nxt;
      rsp_zero_force <= zero_nxt;
      address_pointer_0 <= pif.ptr0;
      address_pointer_1 <= pif.ptr1;
      address_pointer_2 <= pif.ptr2;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  self_read_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && state_r == iag_pkg::IAG_IDLE && hit != 2'h0 && phit != 2'h0 && !acc_write
    |=> rsp_valid && rsp_rdata == 8'h00 && rsp_zero_force && !mem_rd && !mem_wr)
    else $error("self reference read not zero");
  postinc_step_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && state_r == iag_pkg::IAG_IDLE && hit == 2'h1 && acc_addr[2:0] == 3'h6
      && phit == 2'h0 && bhit == 2'h0
    |=> mem_addr == $past(pif.ptr0) && pif.ptr0 == $past(pif.ptr0) + 12'h001)
    else $error("post increment wrong");
  postdec_step_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && state_r == iag_pkg::IAG_IDLE && hit == 2'h2 && acc_addr[2:0] == 3'h5
      && phit == 2'h0 && bhit == 2'h0
    |=> pif.ptr1 == $past(pif.ptr1) - 12'h001)
    else $error("post decrement wrong");
  preinc_addr_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && state_r == iag_pkg::IAG_IDLE && hit == 2'h1 && acc_addr[2:0] == 3'h4 && phit == 2'h0
    |=> mem_addr == $past(pif.ptr0) + 12'h001)
    else $error("pre increment address wrong");
  indexed_keep_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && state_r == iag_pkg::IAG_IDLE && hit == 2'h3 && acc_addr[2:0] == 3'h3
      && phit == 2'h0 && !(acc_write && bhit != 2'h0)
    |=> pif.ptr2 == $past(pif.ptr2)
      && mem_addr == $past(pif.ptr2) + {{4{$past(working_accumulator[7])}}, $past(working_accumulator)})
    else $error("indexed access wrong");
  read_return_a: assert property (@(posedge clk) disable iff (rst)
    mem_rd |=> rsp_valid && rsp_rdata == $past(mem_rdata) && !mem_rd)
    else $error("read data not returned");
  self_write_nop_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && state_r == iag_pkg::IAG_IDLE && hit != 2'h0 && phit != 2'h0 && acc_write
    |=> !mem_wr && !mem_rd && pif.ptr0 == $past(pif.ptr0) && pif.ptr1 == $past(pif.ptr1)
      && pif.ptr2 == $past(pif.ptr2))
    else $error("self write not nop");
  plain_keep_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && state_r == iag_pkg::IAG_IDLE && hit == 2'h1 && acc_addr[2:0] == 3'h7
      && !(acc_write && bhit != 2'h0)
    |=> pif.ptr0 == $past(pif.ptr0))
    else $error("plain access changed pointer");
endmodule : iag_core

// ===== sim/iag_mem_model.sv
// Data memory model behind the address generator
`timescale 1ns/100ps
module iag_mem_model (
  input wire logic clk,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last_r = 8'h00;
  logic hold_r = 1'b0;
  // Known pattern so each address within a 256-byte block reads back a distinct value
  initial for (int a = 0; a < 4096; a++) mem[a] = a[7:0] ^ {a[11:8], 4'h5};
  // Write on strobe; read data is held one cycle after the strobe
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) last_r <= mem[mem_addr];
    hold_r <= mem_rd;
  end
  // Outside the valid window show the inverse, so stale data is never mistaken for good
  assign mem_rdata = mem_rd ? mem[mem_addr] : (hold_r ? last_r : ~last_r);
endmodule : iag_mem_model

// ===== sim/indirect_address_generator_tb.sv
// Self-checking testbench of the indirect address generator
`timescale 1ns/100ps
`include "iag_map.svh"
module indirect_address_generator_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic acc_valid = 1'b0;
  logic acc_write = 1'b0;
  logic [11:0] acc_addr = 12'h000;
  logic [7:0] acc_wdata = 8'h00;
  logic [7:0] working_accumulator = 8'h00;
  logic [7:0] mem_rdata, mem_wdata, rsp_rdata, rd;
  logic [11:0] mem_addr, ptr0, ptr1, ptr2, ma;
  logic mem_rd, mem_wr, rsp_valid, rsp_zero_force, z, st;
  int miscompares = 0;
  int checked = 0;
  always #50 clk = ~clk;
  iag_core DUT (.clk(clk), .rst(rst), .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .working_accumulator(working_accumulator), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_zero_force(rsp_zero_force), .address_pointer_0(ptr0),
    .address_pointer_1(ptr1), .address_pointer_2(ptr2));
  iag_mem_model mem_i (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // ----------------
  // Shared tasks
  // ----------------
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [11:0] port(input logic [1:0] n, input logic [2:0] ofs);
    return `IAG_PORT_BASE + {7'h00, n, 3'h0} + {9'h000, ofs};
  endfunction : port
  // One access; the trailing idle cycle keeps reads apart and lets pointer outputs settle
  task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] w);
    bit done;
    done = 1'b0;
    st = 1'b0;
    @(negedge clk);
    {acc_valid, acc_write, acc_addr, acc_wdata, working_accumulator} = {1'b1, wr, a, d, w};
    for (int i = 0; i < 4 && !done; i++) begin
      @(negedge clk);
      acc_valid = 1'b0;
      if (mem_rd === 1'b1 || mem_wr === 1'b1) {st, ma} = {1'b1, mem_addr};
      if (rsp_valid === 1'b1) {done, rd, z} = {1'b1, rsp_rdata, rsp_zero_force};
    end
    if (!done) begin
      miscompares++;
      $display("Error at %0t: no response", $time);
      print_verdict();
    end
    @(negedge clk);
  endtask : acc
  // Pointer 2 stays at zero, so its indexed port with a negative offset reaches the pointer bytes
  task automatic load_ptr(input logic [1:0] n, input logic [11:0] v);
    acc(1'b1, port(2'h2, `IAG_OFS_INDEX), v[7:0], 8'hD8 + {5'h00, n, 1'b0});
    chk(ma, 12'hFD8 + {9'h000, n, 1'b0});
    acc(1'b1, port(2'h2, `IAG_OFS_INDEX), {4'hA, v[11:8]}, 8'hD9 + {5'h00, n, 1'b0});
  endtask : load_ptr
  task automatic s_steps();
    chk(ptr0, `IAG_PTR_RST);
    load_ptr(2'h0, 12'h0FF);
    chk(ptr0, 12'h0FF);
    chk(ptr2, 12'h000);
    acc(1'b0, port(2'h0, `IAG_OFS_INC_AFTER), 8'h00, 8'h00);
    chk({st, ma}, 13'h10FF);
    chk({4'h0, rd}, {4'h0, 8'hFF ^ 8'h05});
    chk(ptr0, 12'h100);
    acc(1'b1, port(2'h0, `IAG_OFS_DEC_AFTER), 8'h3C, 8'h00);
    chk(ma, 12'h100);
    chk(ptr0, 12'h0FF);
    acc(1'b0, port(2'h0, `IAG_OFS_INC_BEFORE), 8'h00, 8'h00);
    chk({ma[7:0], rd}, 16'h003C);
    acc(1'b0, port(2'h0, `IAG_OFS_PLAIN), 8'h00, 8'h00);
    chk({ma, ptr0}, 24'h100100);
    acc(1'b0, port(2'h0, `IAG_OFS_INDEX), 8'h00, 8'h80);
    chk({ma, ptr0}, 24'h080100);
    acc(1'b0, port(2'h0, `IAG_OFS_INDEX), 8'h00, 8'h7F);
    chk({ma, ptr0}, 24'h17F100);
    // Indexed read through pointer 2; pointer loading only ever writes through it
    acc(1'b0, port(2'h2, `IAG_OFS_INDEX), 8'h00, 8'h10);
    chk({ma, ptr2}, 24'h010000);
    chk({4'h0, rd}, 12'h015);
  endtask : s_steps
  task automatic s_self();
    load_ptr(2'h1, port(2'h0, `IAG_OFS_PLAIN));
    acc(1'b0, port(2'h1, `IAG_OFS_PLAIN), 8'h00, 8'h00);
    chk({st, z, 2'h0, rd}, 12'h400);
    acc(1'b1, port(2'h1, `IAG_OFS_PLAIN), 8'h77, 8'h00);
    chk({st, z}, 2'h0);
  endtask : s_self
  task automatic s_ptr_byte();
    load_ptr(2'h1, 12'hFD8);
    acc(1'b1, port(2'h1, `IAG_OFS_INC_AFTER), 8'h21, 8'h00);
    chk(ptr0, 12'h121);
    chk(ptr1, 12'hFD8);
    load_ptr(2'h1, 12'hFFF);
    acc(1'b1, port(2'h1, `IAG_OFS_INC_AFTER), 8'h00, 8'h00);
    chk({z, ma, ptr1}, 25'h0FFF000);
    acc(1'b0, port(2'h1, `IAG_OFS_DEC_AFTER), 8'h00, 8'h00);
    chk({z, ma, ptr1}, 25'h0000FFF);
  endtask : s_ptr_byte
  task automatic s_ignore();
    @(negedge clk);
    {acc_valid, acc_addr} = {1'b1, 12'h010};
    @(negedge clk);
    acc_valid = 1'b0;
    repeat (3) begin
      chk({rsp_valid, mem_rd, mem_wr}, 3'h0);
      @(negedge clk);
    end
  endtask : s_ignore
  // Reset, then the scenarios in turn
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    s_steps();
    s_self();
    s_ptr_byte();
    s_ignore();
    print_verdict();
  end
endmodule : indirect_address_generator_tb
